// >>> logic/cspr_pkg.sv
// constants for the charger status pulse reporter
package cspr_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  // least request strobe low time
  localparam int REQ_LOW_NS = 200;
  localparam int REQ_LOW_CYC = (REQ_LOW_NS + CLK_NS - 1) / CLK_NS;
  // longest strobe before it is discarded
  localparam int REQ_MAX_NS = 100000;
  localparam int REQ_MAX_CYC = REQ_MAX_NS / CLK_NS;
  // report delay and pulse period, nanoseconds
  localparam int RPT_DELAY_NS = 50000;
  // a short period keeps a 23-pulse reply inside a host polling slot
  localparam int PULSE_PER_NS = 10000;
  localparam int RPT_DELAY_CYC = RPT_DELAY_NS / CLK_NS;
  localparam int PULSE_PER_CYC = PULSE_PER_NS / CLK_NS;
  localparam int PULSE_LOW_CYC = PULSE_PER_CYC / 2;
  localparam int CNT_W = 16;
  localparam int CODE_W = 5;
  localparam logic [CODE_W-1:0] CODE_DIE_OT = 5'h01;
  localparam logic [CODE_W-1:0] CODE_BAT_TEMP = 5'h02;
  localparam logic [CODE_W-1:0] CODE_OVP = 5'h03;
  localparam logic [CODE_W-1:0] CODE_HI_BASE = 5'h0D;
  localparam logic [CODE_W-1:0] CODE_LO_BASE = 5'h12;
  localparam logic [CODE_W-1:0] CODE_ERROR = 5'h17;
  // charge phases, offset within a current group
  localparam logic [2:0] PH_COND = 3'h0;
  localparam logic [2:0] PH_REDUCE = 3'h1;
  localparam logic [2:0] PH_CC = 3'h2;
  localparam logic [2:0] PH_CV = 3'h3;
  localparam logic [2:0] PH_DONE = 3'h4;
  localparam logic [2:0] PH_LAST = PH_DONE;
  // input synchroniser depth
  localparam int SYNC_LEN = 3;
endpackage

// >>> logic/cspr_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cspr_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin and filtered level
  input  wire logic pinIn,
  output logic      levelOut
);
  logic [cspr_pkg::SYNC_LEN-1:0] stage_r;
  wire                            agree;

  // stage 0 is only read by stage 1
  assign agree = (stage_r[1] == stage_r[2]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_r  <= '1;
      levelOut <= 1'b1;
    end else begin
      stage_r <= {stage_r[1:0], pinIn};
      if (agree) begin
        levelOut <= stage_r[2];
      end
    end
  end
endmodule

// >>> logic/cspr_reporter.sv
// status line request decoder and reply pulse burst generator
`timescale 1ns/1ps
module cspr_reporter (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // shared status line
  input  wire logic       lineIn,
  output logic            lineOut,
  output logic            lineOe_n,
  // charger state
  input  wire logic       dieOverTemp,
  input  wire logic       batOverTemp,
  input  wire logic       overVoltage,
  input  wire logic       current_level_select,
  input  wire logic [2:0] chargePhase,
  // pass device and activity
  output logic            passEnable,
  output logic            burstBusy
);
  typedef enum {ST_IDLE, ST_STROBE, ST_DELAY, ST_LOW, ST_HIGH} cspr_state_e;

  cspr_state_e                  state_r, state_nxt;
  cspr_state_e                  stateGo;
  logic [cspr_pkg::CNT_W-1:0]   tmr_r, tmr_nxt;
  logic [cspr_pkg::CODE_W-1:0]  left_r, left_nxt;
  logic                         lineSync;
  wire  [cspr_pkg::CODE_W-1:0]  code;
  wire                          strobeOk;
  wire                          strobeLong;
  wire                          drive_nxt;

  function automatic logic [cspr_pkg::CNT_W-1:0] cyc(input int n);
    cyc = n[cspr_pkg::CNT_W-1:0];
  endfunction

  cspr_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinIn    (lineIn),
    .levelOut (lineSync)
  );

  // faults outrank phases; bad phase reports the error code
  assign code = dieOverTemp ? cspr_pkg::CODE_DIE_OT :
                batOverTemp ? cspr_pkg::CODE_BAT_TEMP :
                overVoltage ? cspr_pkg::CODE_OVP :
                (chargePhase > cspr_pkg::PH_LAST) ? cspr_pkg::CODE_ERROR :
                current_level_select ?
                  cspr_pkg::CODE_HI_BASE + {2'b00, chargePhase} :
                  cspr_pkg::CODE_LO_BASE + {2'b00, chargePhase};

  // the release is seen one count after the last low cycle
  assign strobeOk   = (tmr_r >= cyc(cspr_pkg::REQ_LOW_CYC - 1));
  assign strobeLong = (tmr_r >= cyc(cspr_pkg::REQ_MAX_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = tmr_r + 1'b1;
    left_nxt  = left_r;
    case (state_r)
      ST_IDLE: begin
        tmr_nxt = '0;
        if (!lineSync) begin
          state_nxt = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (lineSync) begin
          tmr_nxt = '0;
          // only a full-length strobe is a request; short glitches are dropped
          state_nxt = strobeOk ? ST_DELAY : ST_IDLE;
          left_nxt  = code;
        end else if (strobeLong) begin
          tmr_nxt = tmr_r;                           // hold until release
        end
      end
      ST_DELAY: begin
        if (tmr_r == cyc(cspr_pkg::RPT_DELAY_CYC - 1)) begin
          tmr_nxt   = '0;
          state_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (tmr_r == cyc(cspr_pkg::PULSE_LOW_CYC - 1)) begin
          tmr_nxt   = '0;
          left_nxt  = left_r - 1'b1;
          state_nxt = ST_HIGH;
        end
      end
      ST_HIGH: begin
        // line level ignored for the whole burst
        if (tmr_r == cyc(cspr_pkg::PULSE_PER_CYC - cspr_pkg::PULSE_LOW_CYC - 1)) begin
          tmr_nxt   = '0;
          state_nxt = (left_r == '0) ? ST_IDLE : ST_LOW;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        tmr_nxt   = '0;
      end
    endcase
  end

  // a long strobe is also refused: tmr saturates, then release discards it
  wire discardLong = (state_r == ST_STROBE) && lineSync && strobeLong;

  // busy must not flicker for a refused long strobe
  assign stateGo = discardLong ? ST_IDLE : state_nxt;

  assign drive_nxt = (state_nxt == ST_LOW);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      tmr_r      <= '0;
      left_r     <= '0;
      lineOut    <= 1'b0;
      lineOe_n   <= 1'b1;
      passEnable <= 1'b0;
      burstBusy  <= 1'b0;
    end else begin
      state_r    <= stateGo;
      tmr_r      <= tmr_nxt;
      left_r     <= left_nxt;
      lineOut    <= 1'b0;
      lineOe_n   <= !drive_nxt;
      passEnable <= !(batOverTemp || dieOverTemp || overVoltage);
      burstBusy  <= (stateGo == ST_DELAY) || (stateGo == ST_LOW) ||
                    (stateGo == ST_HIGH);
    end
  end

  sequence s_low_phase;
    !lineOe_n [*2];
  endsequence

  // counted low run; a repetition of the full pulse length would choke the tools
  logic [cspr_pkg::CNT_W-1:0]   lowRun_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowRun_r <= '0;
    end else if (!lineOe_n) begin
      lowRun_r <= lowRun_r + 1'b1;
    end else begin
      lowRun_r <= '0;
    end
  end

  sequence s_delay_end;
    (state_r == ST_DELAY) && (tmr_r == cyc(cspr_pkg::RPT_DELAY_CYC - 1));
  endsequence

  sequence s_first_low;
    !lineOe_n && burstBusy;
  endsequence

  sequence s_last_high;
    (state_r == ST_HIGH) && (left_r == '0) &&
    (tmr_r == cyc(cspr_pkg::PULSE_PER_CYC - cspr_pkg::PULSE_LOW_CYC - 1));
  endsequence

  sequence s_high_phase;
    lineOe_n [*2];
  endsequence

  a_line_never_high: assert property (@(posedge clk) disable iff (!rst_n)
    !lineOe_n |-> !lineOut) else $error("line driven high");

  a_delay_then_burst: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_STROBE && state_nxt == ST_DELAY && !discardLong) |->
      lineOe_n [*8] ##1 1) else $error("burst started early");

  a_delay_end_low: assert property (@(posedge clk) disable iff (!rst_n)
    s_delay_end |=> s_first_low) else $error("burst late after delay");

  a_pulse_low_len: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(lineOe_n) |-> s_low_phase) else $error("pulse low too short");

  a_pulse_low_exact: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(lineOe_n) |-> (lowRun_r == cyc(cspr_pkg::PULSE_LOW_CYC)))
    else $error("pulse low length wrong");

  a_low_run_bound: assert property (@(posedge clk) disable iff (!rst_n)
    lowRun_r <= cyc(cspr_pkg::PULSE_LOW_CYC)) else $error("pulse low too long");

  a_pulse_high_len: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(lineOe_n) |-> s_high_phase) else $error("pulse high too short");

  a_busy_ignores: assert property (@(posedge clk) disable iff (!rst_n)
    (burstBusy && !lineSync) |=> (state_r != ST_STROBE))
    else $error("line low disturbed burst");

  a_drive_busy: assert property (@(posedge clk) disable iff (!rst_n)
    !lineOe_n |-> burstBusy) else $error("line pulled outside burst");

  a_one_burst: assert property (@(posedge clk) disable iff (!rst_n)
    s_last_high |=> (state_r == ST_IDLE) && lineOe_n) else $error("burst did not end");

  a_pass_off_fault: assert property (@(posedge clk) disable iff (!rst_n)
    batOverTemp |=> !passEnable) else $error("pass device left on");

  a_code_range: assert property (@(posedge clk) disable iff (!rst_n)
    (code >= cspr_pkg::CODE_DIE_OT) && (code <= cspr_pkg::CODE_ERROR) &&
    !(code > cspr_pkg::CODE_OVP && code < cspr_pkg::CODE_HI_BASE))
    else $error("unused code selected");

  a_group_select: assert property (@(posedge clk) disable iff (!rst_n)
    (!dieOverTemp && !batOverTemp && !overVoltage && chargePhase <= cspr_pkg::PH_LAST)
      |-> (current_level_select ? (code <= cspr_pkg::CODE_HI_BASE + 5'h04) :
           (code >= cspr_pkg::CODE_LO_BASE))) else $error("wrong phase group");

  a_short_dropped: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_STROBE && lineSync && !strobeOk) |=> state_r == ST_IDLE)
    else $error("short strobe accepted");

endmodule

// >>> test/cspr_host.sv
// host model that strobes the status line and counts the reply pulses
`timescale 1ns/1ps
module cspr_host (
  // clock
  input  wire logic clk,
  // status line
  input  wire logic line,
  output logic      pullLow
);
  localparam int PER = cspr_pkg::PULSE_PER_CYC;
  initial pullLow = 1'b0;
  // only pulls low or lets go; the pull-up makes every high level
  task automatic ask(input int lowCyc, input bit poke, output int n, output int dly,
                     output int bad);
    int t, hi, last;
    n = 0;
    dly = 0;
    bad = 0;
    hi = 0;
    last = 0;
    @(negedge clk) pullLow = 1'b1;
    repeat (lowCyc) @(negedge clk);
    pullLow = 1'b0;
    for (t = 1; !(n > 0 ? hi > PER : t > 1500); t++) begin
      @(negedge clk);
      if (!line && hi > 0 && !(poke && t > 99 && t < 120)) begin
        n++;
        if (n == 1) dly = t;
        else if (t - last != PER) bad++;
        last = t;
      end
      hi = line ? hi + 1 : 0;
      // stray strobe while the reply is pending must be ignored
      pullLow = poke && t > 99 && t < 110;
    end
  endtask
endmodule

// >>> test/tb.sv
// self-checking bench for the status pulse reporter
`timescale 1ns/1ps
module tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] flt = 3'h0;
  logic       sel = 1'b1;
  logic [2:0] ph = 3'h0;
  logic [7:0] rnd = 8'h52;
  logic       lineOut, lineOe_n, passEnable, burstBusy, hostLow;
  wire        line;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         cyc = 0;
  always #25 clk = ~clk;
  // pull-up: high unless some party pulls low
  assign line = (lineOe_n ? 1'b1 : lineOut) & !hostLow;
  cspr_reporter dut (.clk(clk), .rst_n(rst_n), .lineIn(line), .lineOut(lineOut),
    .lineOe_n(lineOe_n), .dieOverTemp(flt[2]), .batOverTemp(flt[1]),
    .overVoltage(flt[0]), .current_level_select(sel), .chargePhase(ph),
    .passEnable(passEnable), .burstBusy(burstBusy));
  cspr_host host (.clk(clk), .line(line), .pullLow(hostLow));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // priority die, battery, over-voltage, then phase group
  function automatic int expCode(input logic [2:0] f, input logic s, input logic [2:0] p);
    if (f[2]) return 1;
    if (f[1]) return 2;
    if (f[0]) return 3;
    if (p > 3'h4) return 23;
    return (s ? 13 : 18) + p;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic run(input int lowCyc, input bit poke, input int expN);
    int n, d, b;
    host.ask(lowCyc, poke, n, d, b);
    chk("pulse count", expN, n);
    if (expN > 0) chk("reply delay", 1, d >= 1000 && d <= 1008);
    if (expN > 0) chk("bad periods", 0, b);
    chk("busy after", 0, burstBusy);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    @(negedge clk);
    chk("pass on", 1, passEnable);
    for (int i = 0; i < 3; i++) begin
      flt = 3'h7 >> i;
      repeat (2) @(negedge clk);
      chk("pass off", 0, passEnable);
      run(4, 0, expCode(flt, sel, ph));
    end
    flt = 3'h0;
    for (int s = 1; s >= 0; s--) begin
      for (int p = 0; p < 5; p++) begin
        sel = s[0];
        ph = p[2:0];
        rnd = lfsr(rnd);
        // corner of the longest strobe still taken, else random width
        run(p == 0 ? 1999 : 4 + rnd, p == 2, expCode(flt, sel, ph));
      end
    end
    ph = 3'h5;
    run(4, 0, 23);
    run(2, 0, 0);
    run(2000, 0, 0);
    close_out();
  end
endmodule
